// File: rtl/mcupd_core.sv
`timescale 1ns/1ps
`include "mcupd_params.svh"
////////////////////////////////////////////////////////////////////////////////
// one instance per core; rst_b is hard reset
module mcupd_core
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 soft_init,
  input  wire mcupd_pkg::mcupd_req_t req,
  input  wire logic                 ident_fn1,
  input  wire logic                 store_ok,
  input  wire logic [31:0]          store_rev,
  output logic [63:0]               rdata,
  output logic                      load_busy,
  output logic                      patch_active,
  output logic [31:0]               active_rev
);
  mcupd_pkg::mcupd_state_t state_r;
  mcupd_pkg::mcupd_state_t state_nxt;
  logic [63:0] trig_addr_r;
  logic [31:0] rev_field_r;
  logic [31:0] rev_field_nxt;
  logic        v_done;
  logic        v_pass;
  logic [31:0] v_rev;
  logic        start_r;
  //////////////////////////////////////////////////////////////////////////////
  wire trig_wr = req.wr && (req.addr == `MCUPD_ADDR_TRIG);
  wire rev_wr  = req.wr && (req.addr == `MCUPD_ADDR_REV);
  wire rev_rd  = req.rd && (req.addr == `MCUPD_ADDR_REV);
  wire take    = trig_wr && (state_r == mcupd_pkg::MCUPD_IDLE);
  // same revision again: no state change
  wire commit  = v_done && v_pass && !(patch_active && v_rev == active_rev);
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      mcupd_pkg::MCUPD_IDLE:  if (take) state_nxt = mcupd_pkg::MCUPD_FETCH;
      mcupd_pkg::MCUPD_FETCH: if (v_done) state_nxt = mcupd_pkg::MCUPD_DONE;
      mcupd_pkg::MCUPD_DONE:  state_nxt = mcupd_pkg::MCUPD_IDLE;
      default:                state_nxt = mcupd_pkg::MCUPD_IDLE;
    endcase
  end
  always_comb
  begin
    rev_field_nxt = rev_field_r;
    if (rev_wr)
      rev_field_nxt = req.wdata[`MCUPD_REV_MSB:`MCUPD_REV_LSB];
    if (ident_fn1 && patch_active)
      rev_field_nxt = active_rev;
  end
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r      <= mcupd_pkg::MCUPD_IDLE;
      trig_addr_r  <= 64'h0;
      rev_field_r  <= 32'h0;
      patch_active <= 1'b0;
      active_rev   <= 32'h0;
      start_r      <= 1'b0;
      load_busy    <= 1'b0;
      rdata        <= 64'h0;
    end
    else
    begin
      state_r     <= state_nxt;
      start_r     <= take;
      load_busy   <= (state_nxt != mcupd_pkg::MCUPD_IDLE);
      rev_field_r <= rev_field_nxt;
      if (take)
        trig_addr_r <= req.wdata;
      if (commit)
      begin
        patch_active <= 1'b1;
        active_rev   <= v_rev;
      end
      // soft_init deliberately ignored here
      if (soft_init)
        state_r <= state_nxt;
      if (rev_rd)
        rdata <= {rev_field_r, 32'h0};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  mcupd_validate u_val
  (
    .clk       (clk),
    .rst_b     (rst_b),
    .start     (start_r),
    .addr      (trig_addr_r),
    .store_ok  (store_ok),
    .store_rev (store_rev),
    .done      (v_done),
    .pass      (v_pass),
    .rev       (v_rev)
  );
  //////////////////////////////////////////////////////////////////////////////
  property p_hard_reset;
    @(posedge clk) !rst_b |=> !patch_active && active_rev == 32'h0;
  endproperty
  a_hard_reset: assert property (p_hard_reset) else $error("patch survived reset");
  property p_soft_keep;
    @(posedge clk) disable iff (!rst_b) soft_init && patch_active |=> patch_active;
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("patch lost on init");
  property p_ident;
    @(posedge clk) disable iff (!rst_b)
      ident_fn1 && patch_active |=> rev_field_r == $past(active_rev);
  endproperty
  a_ident: assert property (p_ident) else $error("revision not reported");
  property p_noload;
    @(posedge clk) disable iff (!rst_b)
      ident_fn1 && !patch_active && !rev_wr |=> $stable(rev_field_r);
  endproperty
  a_noload: assert property (p_noload) else $error("revision changed");
  property p_low;
    @(posedge clk) disable iff (!rst_b)
      rev_rd |=> rdata[31:0] == 32'h0 && rdata[63:32] == $past(rev_field_r);
  endproperty
  a_low: assert property (p_low) else $error("reserved bits set");
  property p_read;
    @(posedge clk) disable iff (!rst_b) rev_rd && !v_done |=> $stable(active_rev);
  endproperty
  a_read: assert property (p_read) else $error("read disturbed patch");
  property p_fail;
    @(posedge clk) disable iff (!rst_b) v_done && !v_pass |=> $stable(active_rev);
  endproperty
  a_fail: assert property (p_fail) else $error("failed load took effect");
  property p_trig;
    @(posedge clk) disable iff (!rst_b) take |-> ##[5:7] state_r == mcupd_pkg::MCUPD_DONE;
  endproperty
  a_trig: assert property (p_trig) else $error("load did not finish");
  property p_repeat;
    @(posedge clk) disable iff (!rst_b)
      v_done && v_pass && patch_active && v_rev == active_rev |=> $stable(active_rev);
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat load changed");
endmodule : mcupd_core

// File: rtl/mcupd_params.svh
`ifndef MCUPD_PARAMS_SVH
`define MCUPD_PARAMS_SVH
`define MCUPD_ADDR_TRIG      12'h079
`define MCUPD_ADDR_REV       12'h08b
`define MCUPD_REV_LSB        32
`define MCUPD_REV_MSB        63
`define MCUPD_DATA_OFS       64'h0000000000000030
`define MCUPD_ALIGN_MASK     64'h000000000000000f
`define MCUPD_FETCH_CYCLES   8'h04
`endif

// File: rtl/mcupd_pkg.sv
package mcupd_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [63:0] wdata;
  } mcupd_req_t;
  typedef enum logic [2:0] {
    MCUPD_IDLE  = 3'b001,
    MCUPD_FETCH = 3'b010,
    MCUPD_DONE  = 3'b100
  } mcupd_state_t;
endpackage : mcupd_pkg

// File: rtl/mcupd_validate.sv
`timescale 1ns/1ps
`include "mcupd_params.svh"
// judges a patch offered by the firmware store
module mcupd_validate
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic [63:0] addr,
  input  wire logic        store_ok,
  input  wire logic [31:0] store_rev,
  output logic             done,
  output logic             pass,
  output logic [31:0]      rev
);
  logic [7:0] cnt_r;
  logic       busy_r;
  wire        aligned = (addr & `MCUPD_ALIGN_MASK) == 64'h0;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_r  <= 8'h00;
      busy_r <= 1'b0;
      done   <= 1'b0;
      pass   <= 1'b0;
      rev    <= 32'h0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy_r)
      begin
        busy_r <= 1'b1;
        cnt_r  <= `MCUPD_FETCH_CYCLES;
      end
      else if (busy_r)
      begin
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          busy_r <= 1'b0;
          done   <= 1'b1;
          pass   <= store_ok && aligned && (store_rev != 32'h0);
          rev    <= store_rev;
        end
      end
    end
  end
endmodule : mcupd_validate

// File: testbench/microcode_update_load_and_revision_tb.sv
`timescale 1ns/1ps
`include "mcupd_params.svh"
module microcode_update_load_and_revision_tb;
  logic                  clk        = 1'b0;
  logic                  rst_b      = 1'b0;
  logic                  soft_init  = 1'b0;
  logic                  ident_fn1  = 1'b0;
  logic                  store_ok   = 1'b0;
  logic [31:0]           store_rev  = 32'h0;
  mcupd_pkg::mcupd_req_t req        = '0;
  logic [63:0]           rdata;
  logic                  load_busy;
  logic                  patch_active;
  logic [31:0]           active_rev;
  logic [63:0]           q;
  int                    mismatches = 0;
  int                    n_checks   = 0;
  always #10 clk = ~clk;
  mcupd_core u_mcupd_core (.clk(clk), .rst_b(rst_b), .soft_init(soft_init), .req(req),
    .ident_fn1(ident_fn1), .store_ok(store_ok), .store_rev(store_rev), .rdata(rdata),
    .load_busy(load_busy), .patch_active(patch_active), .active_rev(active_rev));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    req = '0;
    cyc(1);
  endtask : wr
  task automatic rd_rev;
    req = '{wr: 1'b0, rd: 1'b1, addr: `MCUPD_ADDR_REV, wdata: 64'h0};
    cyc(1);
    req = '0;
    cyc(1);
    q = rdata;
  endtask : rd_rev
  task automatic ident;
    ident_fn1 = 1'b1;
    cyc(1);
    ident_fn1 = 1'b0;
    cyc(1);
  endtask : ident
  // trigger a load and wait for it to settle
  task automatic load(input logic [63:0] a, input logic ok, input logic [31:0] rev);
    store_ok = ok;
    store_rev = rev;
    wr(`MCUPD_ADDR_TRIG, a);
    for (int i = 0; i < 20 && load_busy !== 1'b0; i++)
      cyc(1);
    chk(load_busy, 64'h0);
  endtask : load
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_none;
    wr(`MCUPD_ADDR_REV, 64'h0);
    ident;
    rd_rev;
    chk(q, 64'h0);
    chk(patch_active, 64'h0);
  endtask : t_none
  task automatic t_fail;
    load(64'h0000_0000_0000_1038, 1'b1, 32'h5);
    load(64'h0000_0000_0000_1030, 1'b0, 32'h5);
    load(64'h0000_0000_0000_1030, 1'b1, 32'h0);
    chk(patch_active, 64'h0);
    chk(active_rev, 64'h0);
  endtask : t_fail
  task automatic t_load;
    load(64'h0000_0001_0000_1030, 1'b1, 32'h12);
    chk(patch_active, 64'h1);
    chk(active_rev, 64'h12);
    wr(`MCUPD_ADDR_REV, 64'hffff_ffff_ffff_ffff);
    rd_rev;
    chk(q, 64'hffff_ffff_0000_0000);
    wr(`MCUPD_ADDR_REV, 64'h0);
    ident;
    rd_rev;
    chk(q, 64'h0000_0012_0000_0000);
    rd_rev;
    chk(active_rev, 64'h12);
  endtask : t_load
  task automatic t_keep;
    soft_init = 1'b1;
    cyc(2);
    soft_init = 1'b0;
    cyc(1);
    chk(active_rev, 64'h12);
    chk(patch_active, 64'h1);
    load(64'h0000_0001_0000_1030, 1'b1, 32'h12);
    chk({patch_active, active_rev}, 64'h1_0000_0012);
    load(64'h0000_0001_0000_1030, 1'b1, 32'h13);
    chk(active_rev, 64'h13);
  endtask : t_keep
  task automatic t_hard;
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    cyc(1);
    chk({patch_active, active_rev}, 64'h0);
    wr(`MCUPD_ADDR_REV, 64'h0);
    ident;
    rd_rev;
    chk(q, 64'h0);
    load(64'h0000_0000_0000_2030, 1'b1, 32'h12);
    chk({patch_active, active_rev}, 64'h1_0000_0012);
  endtask : t_hard
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(10);
    rst_b = 1'b1;
    cyc(1);
    t_none;
    t_fail;
    t_load;
    t_keep;
    t_hard;
    wrap_up;
  end
  initial
  begin
    #100us;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule : microcode_update_load_and_revision_tb
